// file: bench/adc_link_asserts.sv
// link checker for the converter serial interface
`default_nettype none
module adc_link_asserts (
    // system
    input wire logic sys_clk,
    input wire logic rst_b,
    // serial link
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic conv_b,
    input wire logic sleep_pin,
    input wire logic serial_cmd_in,
    input wire logic dout,
    input wire logic eoc
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ======================================
    // link timing
    a_sclk_idle_low: assert property (cs_b |-> !sclk)
        else $error("shift clock high while deselected");
    a_sclk_high_time: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
        else $error("shift clock high phase wrong");
    a_sclk_low_time: assert property ($fell(sclk) && !cs_b |-> !sclk[*8])
        else $error("shift clock low phase too short");
    a_cmd_bit_stable: assert property (sclk |-> $stable(serial_cmd_in))
        else $error("command bit moved while clock high");
    a_conv_b_stable: assert property (sclk |-> $stable(conv_b))
        else $error("convert strobe moved in a frame");
    // conversion
    a_conv_ends_bound: assert property ($fell(eoc) |-> ##[1:600] eoc)
        else $error("conversion never ended");
    a_select_when_idle: assert property ($fell(cs_b) |-> eoc)
        else $error("select dropped during conversion");
    a_no_clock_in_conv: assert property (!eoc |-> !sclk)
        else $error("shift clock during conversion");
endmodule
`default_nettype wire

// file: bench/adc_serial_command_interface_tb.sv
// self-checking bench for both ends of the converter link
`default_nettype none
module adc_serial_command_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic [12:0] sample_in = 13'h0;
    logic [3:0]  mux_addr;
    logic        converting;
    logic        powered;
    logic [31:0] seed = 32'hdee88651;
    logic [31:0] rx;
    int          lowcnt = 0;
    int          failures = 0;
    int          checks = 0;
    int          a, k, d, e, t0;
    int          wins[4] = '{6, 10, 18, 34};
    adc_link_if lk ();
    adc_dev #(.CAL_CCLKS(100), .ZERO_CCLKS(10), .WAKE_CCLKS(5)) u_adc_dev (
        .sys_clk(sys_clk), .rst_b(rst_b), .link(lk), .sample_in(sample_in),
        .mux_addr(mux_addr), .converting(converting), .powered(powered));
    adc_host u_adc_host (
        .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .link(lk));
    adc_link_asserts u_adc_link_asserts (
        .sys_clk(sys_clk), .rst_b(rst_b), .sclk(lk.sclk), .cs_b(lk.cs_b),
        .conv_b(lk.conv_b), .sleep_pin(lk.sleep_pin),
        .serial_cmd_in(lk.serial_cmd_in), .dout(lk.dout), .eoc(lk.eoc));
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (lk.eoc === 1'b0) lowcnt <= lowcnt + 1;
    // ======================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // received status, first bit sent lands highest
    function automatic logic [31:0] stat_exp(input logic sgn);
        return {26'h0, 1'b1, 1'b0, sgn, 1'b1, 2'b00};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] ad,
                       input logic [31:0] wd, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic xfer(input logic [7:0] ins, input logic [4:0] n,
                        input logic cv);
        int i;
        ahb(1'b1, 8'h00, {15'h0, cv, 3'h0, n, ins}, rx);
        rx = 32'h0100_0000;
        for (i = 0; i < 3000 && rx[24] !== 1'b0; i++) begin
            ahb(1'b0, 8'h04, 32'h0, rx);
        end
        if (rx[24] !== 1'b0) failures++;
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        failures++;
        report_and_stop();
    end
    // ======================================
    // scenarios
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        ahb(1'b0, 8'hfc, 32'h0, rx);
        chk(rx, 32'h0);
        xfer(8'h30, 5'd10, 1'b1);
        xfer(8'h30, 5'd10, 1'b1);
        chk(rx & 32'h3ff, stat_exp(1'b1));
        for (a = 0; a < 4; a++) begin
            seed = lfsr(seed);
            sample_in <= seed[12:0];
            xfer({6'h1c, a[0], a[1]}, 5'd8, 1'b1);
            t0 = lowcnt;
            xfer({4'h0, seed[16:13]}, 5'd8, 1'b0);
            for (k = 0; k < 2000 && lk.eoc !== 1'b1; k++) @(posedge sys_clk);
            d = lowcnt - t0;
            e = (wins[a] + 13) * 10;
            chk({31'h0, d + 10 >= e && d <= e + 10}, 32'h1);
            xfer(8'h00, 5'd13, 1'b1);
            chk(rx & 32'h1fff, {19'h0, seed[12:0]});
            chk({28'h0, mux_addr}, {28'h0, seed[16:13]});
            chk({31'h0, converting}, 32'h0);
        end
        xfer(8'hb0, 5'd8, 1'b1);
        xfer(8'h30, 5'd10, 1'b1);
        xfer(8'h30, 5'd10, 1'b1);
        chk(rx & 32'h3ff, stat_exp(1'b0));
        xfer(8'h10, 5'd8, 1'b1);
        xfer(8'h30, 5'd10, 1'b1);
        xfer(8'h30, 5'd10, 1'b1);
        chk(rx & 32'h3ff, stat_exp(1'b0) | 32'h80);
        for (k = 0; k < 40 && rx[7] !== 1'b0; k++) xfer(8'h30, 5'd10, 1'b1);
        chk(rx & 32'h3ff, stat_exp(1'b0));
        xfer(8'hf1, 5'd8, 1'b1);
        xfer(8'h30, 5'd10, 1'b1);
        xfer(8'h30, 5'd10, 1'b1);
        chk(rx & 32'h3ff, stat_exp(1'b0) | 32'h1);
        xfer(8'hf0, 5'd8, 1'b1);
        xfer(8'hd0, 5'd8, 1'b1);
        repeat (8) @(posedge sys_clk);
        chk({31'h0, powered}, 32'h0);
        ahb(1'b1, 8'h08, 32'h1, rx);
        ahb(1'b0, 8'h08, 32'h0, rx);
        chk(rx, 32'h1);
        xfer(8'h50, 5'd8, 1'b1);
        repeat (8) @(posedge sys_clk);
        chk({31'h0, powered}, 32'h0);
        ahb(1'b1, 8'h08, 32'h0, rx);
        repeat (80) @(posedge sys_clk);
        chk({31'h0, powered}, 32'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: rtl/adc_dev.sv
// converter end: serial command decode, conversion sequencing, readout
// Overview of operation
// RULE1: power-up defaults: 12+sign, MSB first, acq 10
// RULE2: conv high reads only (code: conv high blocks only conversion starts, other instructions execute); cs high idles
// RULE3: status cal flag high while calibrating
// RULE4: status holds wake, sleep, length, sign, justification
// RULE5: first status read after calibration is garbage
// RULE6: controller stays silent during a conversion
// RULE7: select falling during conversion aborts it
// RULE8: end-of-conversion output marks conversion finished
// RULE9: result shifts out in the next transfer
// RULE10: acquisition and sign instructions start nothing
// RULE11: acquisition window of 6/10/18/34 conversion clocks
// RULE12: conversion instructions reselect channel, start conversion
// RULE13: controller clocks match previously chosen format
// RULE14: clocks per transfer equal output word length
// RULE15: select held low: 13 clocks after power-up
// RULE16: format changes only on conversion or sign
// RULE17: strobed select: short instructions need 8 clocks
// RULE18: status bit 9 high in test mode
// RULE19: pin sleep overrides software wake
// RULE20: one command bit per clock, first first
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`default_nettype none
`include "adc_link_map.svh"
module adc_dev #(
    parameter int CONVERSION_CLOCK_DIV   = 10,
    parameter int CAL_CCLKS  = 1000,
    parameter int ZERO_CCLKS = 100,
    parameter int WAKE_CCLKS = 100
) (
    // system
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // serial link
    adc_link_if.dev          link,
    // analog front end
    input  wire logic [12:0] sample_in,
    output logic      [3:0]  mux_addr,
    output logic             converting,
    output logic             powered
);
    // ========================================================
    // input synchronisers and edges
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic       sclk_q_r;
    logic       cs_q_r;
    logic       pin_q_r;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r  <= `ADC_LINK_IDLE;
            sync2_r  <= `ADC_LINK_IDLE;
            sclk_q_r <= 1'b0;
            cs_q_r   <= 1'b1;
            pin_q_r  <= 1'b0;
        end else begin
            sync1_r  <= {link.sclk, link.cs_b, link.conv_b,
                         link.sleep_pin, link.serial_cmd_in};
            sync2_r  <= sync1_r;
            sclk_q_r <= sync2_r[4];
            cs_q_r   <= sync2_r[3];
            pin_q_r  <= sync2_r[1];
        end
    end

    wire sclk_s    = sync2_r[4];
    wire cs_s      = sync2_r[3];
    wire conv_s    = sync2_r[2];
    wire pin_s     = sync2_r[1];
    wire di_s      = sync2_r[0];
    wire active    = !cs_s;                          // see RULE2
    wire sclk_rise = active && sclk_s && !sclk_q_r;
    wire sclk_fall = active && !sclk_s && sclk_q_r;
    wire cs_rise   = cs_s && !cs_q_r;
    wire cs_fall   = !cs_s && cs_q_r;
    wire pin_fall  = !pin_s && pin_q_r;

    // ========================================================
    // conversion clock enable
    logic [7:0] conversion_clock_cnt_r;
    wire        conversion_clock_en = (conversion_clock_cnt_r == 8'(CONVERSION_CLOCK_DIV - 1));

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            conversion_clock_cnt_r <= 8'h00;
        else
            conversion_clock_cnt_r <= conversion_clock_en ? 8'h00 : conversion_clock_cnt_r + 8'h01;
    end

    // ========================================================
    // configuration and state registers
    adc_link_pkg::fmt_e      fmt_r;
    adc_link_pkg::cv_state_e state_r;
    logic        lsb_r;
    logic        sign_r;
    logic [1:0]  acq_sel_r;
    logic        test_r;
    logic        sw_pd_r;
    logic        src_status_r;
    logic [15:0] cnt_r;
    logic [12:0] result_r;
    logic        eoc_r;
    logic        powered_q_r;
    logic [15:0] wake_cnt_r;
    logic [4:0]  bit_cnt_r;
    logic [7:0]  ins_sr_r;
    logic [16:0] out_sr_r;
    logic        dout_r;
    logic        conv_ok_r;
    logic        cal_dirty_r;

    // ========================================================
    // frame decode
    wire [4:0] base_len = (fmt_r == adc_link_pkg::FMT_8)  ? `ADC_LEN_8 :
                          (fmt_r == adc_link_pkg::FMT_16) ? `ADC_LEN_16 :
                                                            `ADC_LEN_12;
    wire [4:0] exp_len  = base_len + {4'h0, sign_r};  // see RULE14
    wire [7:0] ins_full = (bit_cnt_r < `ADC_INS_BITS) ?
                          {di_s, ins_sr_r[7:1]} : ins_sr_r;  // see RULE20
    wire last_bit = sclk_rise && (bit_cnt_r + 5'h01 == exp_len);  // see RULE15
    wire exec     = last_bit ||
                    (cs_rise && bit_cnt_r >= `ADC_INS_BITS);  // see RULE17
    wire [7:0] exec_ins = last_bit ? ins_full : ins_sr_r;
    wire [3:0] mode     = {exec_ins[4], exec_ins[5], exec_ins[6], exec_ins[7]};
    wire [2:0] op       = mode[2:0];
    wire is_conv  = !mode[3];
    wire is_cal   = mode[3] && (op == `ADC_OP_AUTOCAL ||
                                op == `ADC_OP_AUTOZERO);
    wire pwr_now  = !pin_s && !sw_pd_r;              // see RULE19
    wire idle     = (state_r == adc_link_pkg::CV_IDLE);
    wire cal_busy = (state_r == adc_link_pkg::CV_CAL);
    wire in_conv  = (state_r == adc_link_pkg::CV_ACQ) ||
                    (state_r == adc_link_pkg::CV_RUN);
    wire start_conv = exec && is_conv && conv_ok_r && pwr_now && idle;
    wire start_cal  = exec && is_cal && pwr_now && idle;
    wire abort      = (in_conv && cs_fall) ||        // see RULE7
                      (!idle && !pwr_now);
    wire [15:0] acq_len = (acq_sel_r == 2'h0) ? `ADC_ACQ_6 :
                          (acq_sel_r == 2'h1) ? `ADC_ACQ_10 :
                          (acq_sel_r == 2'h2) ? `ADC_ACQ_18 :
                                                `ADC_ACQ_34;  // see RULE11
    wire adc_link_pkg::fmt_e fmt_dec =
        (exec_ins[6] && !exec_ins[7]) ? adc_link_pkg::FMT_8 :
        (!exec_ins[6] && exec_ins[7]) ? adc_link_pkg::FMT_16 :
                                        adc_link_pkg::FMT_12;

    // ========================================================
    // status and result words, first bit in bit 16
    wire [9:0] status = {test_r, 1'b0, !lsb_r, sign_r,  // see RULE18
                         fmt_r == adc_link_pkg::FMT_16,
                         fmt_r == adc_link_pkg::FMT_12,
                         fmt_r == adc_link_pkg::FMT_8,
                         cal_busy, !powered_q_r,          // see RULE3
                         wake_cnt_r != 16'h0000};         // see RULE4

    function automatic logic [16:0] pack_result(
        input logic [12:0]        r,
        input adc_link_pkg::fmt_e f,
        input logic               lsb,
        input logic               sgn
    );
        logic [15:0] dv;
        logic [16:0] w;
        int          n;
        int          s;
        w = '0;
        s = int'(sgn);
        case (f)
            adc_link_pkg::FMT_8: begin
                dv = {8'h00, r[11:4]};
                n  = int'(`ADC_LEN_8);
            end
            adc_link_pkg::FMT_16: begin
                dv = {{4{r[12]}}, r[11:0]};
                n  = int'(`ADC_LEN_16);
            end
            default: begin
                dv = {4'h0, r[11:0]};
                n  = int'(`ADC_LEN_12);
            end
        endcase
        for (int i = 0; i < 17; i++) begin
            if (lsb) begin
                if (i < n)
                    w[16 - i] = dv[i];
                else if (i == n)
                    w[16 - i] = sgn & r[12];
            end else begin
                if (sgn && i == 0)
                    w[16] = r[12];
                else if (i < n + s)
                    w[16 - i] = dv[n - 1 - i + s];
            end
        end
        return w;
    endfunction

    logic [16:0] status_word;
    always_comb begin
        status_word = '0;
        for (int i = 0; i < 10; i++)
            status_word[16 - i] = status[i];
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            cal_dirty_r <= 1'b0;
        else if (start_cal)
            cal_dirty_r <= 1'b1;
        else if (sclk_rise && bit_cnt_r == 5'h00)
            cal_dirty_r <= 1'b0;
    end

    wire [16:0] load_word = cal_dirty_r  ? {1'b0, cnt_r} :  // see RULE5
                            src_status_r ? status_word :
                            pack_result(result_r, fmt_r, lsb_r, sign_r);

    // ========================================================
    // serial shifting
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_r <= 5'h00;
            ins_sr_r  <= 8'h00;
            conv_ok_r <= 1'b0;
        end else if (cs_rise || last_bit) begin
            bit_cnt_r <= 5'h00;
        end else if (sclk_rise) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            ins_sr_r  <= ins_full;                       // see RULE20
            if (bit_cnt_r == 5'h00)
                conv_ok_r <= !conv_s;                    // see RULE2
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_sr_r <= 17'h00000;
            dout_r   <= 1'b0;
        end else if (bit_cnt_r == 5'h00 && !sclk_rise) begin
            out_sr_r <= load_word;                       // see RULE9
            dout_r   <= load_word[16];
        end else if (sclk_fall) begin
            out_sr_r <= {out_sr_r[15:0], 1'b0};
            dout_r   <= out_sr_r[15];
        end
    end

    // ========================================================
    // configuration updates
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fmt_r        <= adc_link_pkg::FMT_12;        // see RULE1
            lsb_r        <= 1'b0;
            sign_r       <= 1'b1;
            acq_sel_r    <= `ADC_ACQ_RST;
            test_r       <= 1'b0;
            sw_pd_r      <= 1'b0;
            src_status_r <= 1'b0;
            mux_addr     <= 4'h0;
        end else begin
            if (pin_fall)
                sw_pd_r <= 1'b0;
            if (exec) begin
                src_status_r <= mode[3] && op == `ADC_OP_STATUS;
                if (start_conv) begin
                    mux_addr <= exec_ins[3:0];           // see RULE12
                    fmt_r    <= fmt_dec;                 // see RULE16
                    lsb_r    <= exec_ins[5];
                end
                if (mode[3]) begin
                    case (op)                            // see RULE10
                        `ADC_OP_PWRUP: sw_pd_r <= 1'b0;  // see RULE19
                        `ADC_OP_PWRDN: sw_pd_r <= 1'b1;
                        `ADC_OP_SIGN:  sign_r  <= exec_ins[0];
                        `ADC_OP_ACQ:   acq_sel_r <= {exec_ins[0],
                                                     exec_ins[1]};
                        `ADC_OP_MODE:  test_r  <= exec_ins[0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // ========================================================
    // conversion and calibration sequencer
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r  <= adc_link_pkg::CV_IDLE;
            cnt_r    <= 16'h0000;
            result_r <= 13'h0000;
        end else if (abort) begin
            state_r <= adc_link_pkg::CV_IDLE;
            cnt_r   <= 16'h0000;
        end else if (start_conv) begin
            state_r <= adc_link_pkg::CV_ACQ;
            cnt_r   <= acq_len;
        end else if (start_cal) begin
            state_r <= adc_link_pkg::CV_CAL;
            cnt_r   <= (op == `ADC_OP_AUTOCAL) ? 16'(CAL_CCLKS) :
                                                 16'(ZERO_CCLKS);
        end else if (conversion_clock_en && !idle) begin
            if (cnt_r > 16'h0001) begin
                cnt_r <= cnt_r - 16'h0001;
            end else begin
                case (state_r)
                    adc_link_pkg::CV_ACQ: begin
                        state_r <= adc_link_pkg::CV_RUN;
                        cnt_r   <= `ADC_CONV_CCLKS;
                    end
                    adc_link_pkg::CV_RUN: begin
                        state_r  <= adc_link_pkg::CV_IDLE;
                        result_r <= sample_in;
                    end
                    default: state_r <= adc_link_pkg::CV_IDLE;
                endcase
            end
        end
    end

    // ========================================================
    // end of conversion and wake tracking
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            eoc_r       <= 1'b1;
            powered_q_r <= 1'b1;
            wake_cnt_r  <= 16'h0000;
        end else begin
            eoc_r       <= !in_conv;                     // see RULE8
            powered_q_r <= pwr_now;
            if (!pwr_now)
                wake_cnt_r <= 16'h0000;
            else if (!powered_q_r)
                wake_cnt_r <= 16'(WAKE_CCLKS);
            else if (conversion_clock_en && wake_cnt_r != 16'h0000)
                wake_cnt_r <= wake_cnt_r - 16'h0001;
        end
    end

    assign link.dout  = dout_r;
    assign link.eoc   = eoc_r;
    assign converting = !eoc_r;
    assign powered    = powered_q_r;
endmodule
`default_nettype wire

// file: rtl/adc_host.sv
// controller end: AHB-Lite registers driving the converter serial link
`default_nettype none
`include "adc_link_map.svh"
module adc_host #(
    parameter int SCLK_HALF = 8
) (
    // system
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // serial link
    adc_link_if.host         link
);
    // ========================================================
    // registers
    adc_link_pkg::host_state_e state_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [17:0] cmd_r;
    logic        sleep_r;
    logic [16:0] rx_r;
    logic [1:0]  dout_sync_r;
    logic [1:0]  eoc_sync_r;
    logic [7:0]  div_r;
    logic [4:0]  bits_r;
    logic        sclk_r;
    logic        cs_b_r;
    logic        conv_b_r;
    logic        di_r;

    wire busy     = (state_r != adc_link_pkg::HS_IDLE);
    wire ap       = hsel && hready && htrans[1];
    wire tick     = (div_r == 8'(SCLK_HALF - 1));
    wire dout_s   = dout_sync_r[1];
    wire eoc_s    = eoc_sync_r[1];
    wire cmd_wr   = wr_pend_r && wr_addr_r == `HOST_REG_CMD && !busy;
    wire ctrl_wr  = wr_pend_r && wr_addr_r == `HOST_REG_CTRL;
    wire [4:0] cnt = cmd_r[`HOST_CMD_CNT_LSB +: 5];  // see RULE13
    wire [31:0] rd_mux =
        (haddr == `HOST_REG_CMD)  ? {14'h0000, cmd_r} :
        (haddr == `HOST_REG_STAT) ? {6'h00, eoc_s, busy, 7'h00, rx_r} :
        (haddr == `HOST_REG_CTRL) ? {31'h00000000, sleep_r} :
                                    32'h00000000;

    // ========================================================
    // bus slave, zero wait states
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata    <= 32'h00000000;
        end else begin
            wr_pend_r <= ap && hwrite;
            if (ap)
                wr_addr_r <= haddr;
            if (ap && !hwrite)
                hrdata <= rd_mux;
        end
    end

    // ========================================================
    // link input synchronisers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dout_sync_r <= 2'h0;
            eoc_sync_r  <= 2'h3;
        end else begin
            dout_sync_r <= {dout_sync_r[0], link.dout};
            eoc_sync_r  <= {eoc_sync_r[0], link.eoc};
        end
    end

    // ========================================================
    // transfer engine
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r  <= adc_link_pkg::HS_IDLE;
            cmd_r    <= 18'h00000;
            sleep_r  <= 1'b0;
            rx_r     <= 17'h00000;
            div_r    <= 8'h00;
            bits_r   <= 5'h00;
            sclk_r   <= 1'b0;
            cs_b_r   <= 1'b1;
            conv_b_r <= 1'b1;
            di_r     <= 1'b0;
        end else begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            if (ctrl_wr)
                sleep_r <= hwdata[0];
            case (state_r)
                adc_link_pkg::HS_IDLE: begin
                    if (cmd_wr) begin
                        cmd_r   <= hwdata[17:0];
                        state_r <= adc_link_pkg::HS_WAIT;
                    end
                end
                adc_link_pkg::HS_WAIT: begin
                    if (eoc_s) begin                     // see RULE6
                        cs_b_r   <= 1'b0;
                        conv_b_r <= cmd_r[`HOST_CMD_CONV];
                        di_r     <= cmd_r[0];            // see RULE20
                        bits_r   <= 5'h00;
                        div_r    <= 8'h00;
                        state_r  <= adc_link_pkg::HS_SHIFT;
                    end
                end
                adc_link_pkg::HS_SHIFT: begin
                    if (tick && !sclk_r) begin
                        sclk_r <= 1'b1;
                        rx_r   <= {rx_r[15:0], dout_s};
                        bits_r <= bits_r + 5'h01;
                    end else if (tick) begin
                        sclk_r <= 1'b0;
                        if (bits_r == cnt) begin         // see RULE14
                            cs_b_r  <= !cmd_r[`HOST_CMD_KEEP];
                            state_r <= adc_link_pkg::HS_TAIL;
                        end else begin
                            di_r <= (bits_r < `ADC_INS_BITS) ?
                                    cmd_r[bits_r[2:0]] : 1'b0;
                        end
                    end
                end
                default: begin
                    if (tick)
                        state_r <= adc_link_pkg::HS_IDLE;
                end
            endcase
        end
    end

    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign link.sclk      = sclk_r;
    assign link.cs_b      = cs_b_r;
    assign link.conv_b    = conv_b_r;
    assign link.sleep_pin = sleep_r;
    assign link.serial_cmd_in = di_r;
endmodule
`default_nettype wire

// file: rtl/adc_link_if.sv
// serial link between converter and its controller
`default_nettype none
interface adc_link_if;
    logic sclk;
    logic cs_b;
    logic conv_b;
    logic sleep_pin;
    logic serial_cmd_in;
    logic dout;
    logic eoc;

    modport dev (
        input  sclk,
        input  cs_b,
        input  conv_b,
        input  sleep_pin,
        input  serial_cmd_in,
        output dout,
        output eoc
    );

    modport host (
        output sclk,
        output cs_b,
        output conv_b,
        output sleep_pin,
        output serial_cmd_in,
        input  dout,
        input  eoc
    );
endinterface
`default_nettype wire

// file: rtl/adc_link_map.svh
// constants for the converter serial link and its controller
`ifndef ADC_LINK_MAP_SVH
`define ADC_LINK_MAP_SVH

// instruction groups, op = {DI5, DI6, DI7} when DI4 is high
`define ADC_OP_AUTOCAL   3'h0
`define ADC_OP_AUTOZERO  3'h1
`define ADC_OP_PWRUP     3'h2
`define ADC_OP_PWRDN     3'h3
`define ADC_OP_STATUS    3'h4
`define ADC_OP_SIGN      3'h5
`define ADC_OP_ACQ       3'h6
`define ADC_OP_MODE      3'h7
`define ADC_INS_BITS     5'h08

// word lengths without sign
`define ADC_LEN_8        5'h08
`define ADC_LEN_12       5'h0c
`define ADC_LEN_16       5'h10

// acquisition windows in conversion clocks
`define ADC_ACQ_6        16'h0006
`define ADC_ACQ_10       16'h000a
`define ADC_ACQ_18       16'h0012
`define ADC_ACQ_34       16'h0022
`define ADC_ACQ_RST      2'h1
`define ADC_CONV_CCLKS   16'h000d

// link idle levels {sclk, cs_b, conv_b, sleep_pin, serial_cmd_in}
`define ADC_LINK_IDLE    5'h0c

// controller register offsets
`define HOST_REG_CMD     8'h00
`define HOST_REG_STAT    8'h04
`define HOST_REG_CTRL    8'h08

// controller command register fields
`define HOST_CMD_CNT_LSB 8
`define HOST_CMD_CONV    16
`define HOST_CMD_KEEP    17

`endif

// file: rtl/adc_link_pkg.sv
// types shared by both ends of the converter serial link
`default_nettype none
package adc_link_pkg;
    typedef enum logic [1:0] {
        FMT_8  = 2'b00,
        FMT_12 = 2'b01,
        FMT_16 = 2'b10
    } fmt_e;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_ACQ  = 2'b01,
        CV_RUN  = 2'b10,
        CV_CAL  = 2'b11
    } cv_state_e;

    typedef enum logic [1:0] {
        HS_IDLE  = 2'b00,
        HS_WAIT  = 2'b01,
        HS_SHIFT = 2'b10,
        HS_TAIL  = 2'b11
    } host_state_e;
endpackage
`default_nettype wire
